// ### verilog/fastlock_pkg.sv
// Shared constants and carrier types for the fastlock and fractional modulus block
package fastlock_pkg;
   localparam int WORD_W = 24;
   localparam int SEL_W = 4;
   localparam logic [3:0] SEL_MODULUS_EXT = 4'hb;
   localparam logic [3:0] SEL_FASTLOCK = 4'hd;
   // Modulus extension word fields
   localparam int FD_HI_LSB = 14;
   localparam int FN_HI_LSB = 4;
   localparam int HI_W = 10;
   localparam int LO_W = 12;
   localparam int FRAC_W = 22;
   // Fastlock word fields
   localparam int CSR_LSB = 22;
   localparam int CSR_W = 2;
   localparam int CPF_LSB = 18;
   localparam int CPF_W = 4;
   localparam int TOC_LSB = 4;
   localparam int TOC_W = 14;
   // Timeout codes
   localparam logic [13:0] TOC_HIZ = 14'h0000;
   localparam logic [13:0] TOC_MANUAL = 14'h0001;
   localparam logic [13:0] TOC_GPO_LOW = 14'h0002;
   localparam logic [13:0] TOC_GPO_HIGH = 14'h0003;
   localparam logic [13:0] TOC_TIMED_MIN = 14'h0004;
   // Values after reset, and the synchroniser depth
   localparam logic [9:0] RST_HI = 10'h000;
   localparam logic [3:0] RST_CPF = 4'h0;
   localparam logic [1:0] RST_CSR = 2'h0;
   localparam logic [13:0] RST_TOC = 14'h0000;
   localparam logic [4:0] PUMP_MULT_IDLE = 5'h01;
   localparam int SYNC_STAGES = 2;

   typedef struct packed {
      logic sclk;
      logic sdata;
      logic latch;
   } serial_pins_s;

   typedef struct packed {
      logic [1:0] cycle_slip_reduction;
      logic [3:0] cpf;
      logic [13:0] toc;
   } fastlock_cfg_s;

   typedef enum logic [2:0] {
      FL_IDLE = 3'b001,
      FL_TIMED = 3'b010,
      FL_MANUAL = 3'b100
   } fl_state_e;
endpackage

// ### verilog/sync_2ff.sv
// Two flip-flop synchroniser for a group of asynchronous pin inputs
`timescale 1ns/1ps
module sync_2ff #(
   parameter int WIDTH = 3
) (
   input wire logic clk_in, // System clock
   input wire logic resetn_in, // Synchronous reset, active low
   input wire logic [WIDTH-1:0] async_in, // Asynchronous levels
   output logic [WIDTH-1:0] sync_out // Synchronised levels
);
   logic [WIDTH-1:0] meta_ff;

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         meta_ff <= '0;
         sync_out <= '0;
      end else begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule // sync_2ff

// ### verilog/rf_fastlock_and_frac_modulus.sv
// Serial-programmed fractional modulus extension and fastlock timeout control
//
// Contract
// - With wide mode off the numerator is the 12 lower bits and the upper ten bits are ignored.
// - With wide mode on the numerator is the upper ten bits joined above the lower twelve.
// - With wide mode off the denominator is the 12 lower bits and the upper ten are don't-care.
// - With wide mode on the denominator is the upper ten bits joined above the lower twelve.
// - Timeout codes 0 to 3 never start timed fastlock.
// - Codes 0, 2 and 3 make the fastlock pin high impedance, low and high.
// - Code 1 drives the pin low and holds fastlock active continuously.
// - Codes 4 to 16383 enable timed fastlock and use the pin as the fastlock output.
// - Timed fastlock lasts twice the timeout code in comparison events, then ends.
// - The pump multiplier is code plus one, applied only while in fastlock.
// - The cycle-slip code scales the detector rate by 1, 1/2, 1/4 or 1/16.
`timescale 1ns/1ps
module rf_fastlock_and_frac_modulus #(
   parameter int TOC_WIDTH = fastlock_pkg::TOC_W
) (
   input wire logic clk_in, // System clock, 10 MHz
   input wire logic resetn_in, // Synchronous reset, active low
   input wire fastlock_pkg::serial_pins_s serial_in, // Serial clock, data, latch pins
   input wire logic wide_mode_in, // 22-bit modulus select
   input wire logic [11:0] frac_num_lo_in, // Lower numerator bits
   input wire logic [11:0] frac_den_lo_in, // Lower denominator bits
   input wire logic comp_event_in, // One pulse per phase comparison
   input wire logic fastlock_start_in, // Pulse that starts a timed fastlock
   output logic [21:0] rf_frac_numerator_out, // Effective numerator
   output logic [21:0] rf_frac_denominator_out, // Effective denominator
   output logic fastlock_active_out, // Loop is in fastlock
   output logic [4:0] pump_mult_out, // Charge pump multiplier
   output logic [4:0] csr_divide_out, // Detector rate divisor 1, 2, 4 or 16
   output logic fastlock_pin_out, // Fastlock pin level
   output logic fastlock_pin_oe_out // Fastlock pin drive enable
);
   // One extra bit holds twice the largest timeout code
   localparam int CNT_W = TOC_WIDTH + 1;

   // Synchronised pins and serial shifter
   fastlock_pkg::serial_pins_s pins_sync;
   logic sclk_d_ff;
   logic latch_d_ff;
   logic [23:0] shift_ff;

   // Stored configuration
   logic [9:0] fn_hi_ff;
   logic [9:0] fd_hi_ff;
   fastlock_pkg::fastlock_cfg_s cfg_ff;

   // Fastlock sequencer
   fastlock_pkg::fl_state_e state_ff;
   fastlock_pkg::fl_state_e nxt_state;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;

   sync_2ff #(
      .WIDTH(3)
   ) u_pin_sync (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .async_in(serial_in),
      .sync_out(pins_sync)
   );

   // Serial capture: shift on clock rise, act on latch rise
   wire sclk_rise = pins_sync.sclk & ~sclk_d_ff;
   wire latch_rise = pins_sync.latch & ~latch_d_ff;
   wire [3:0] word_sel = shift_ff[fastlock_pkg::SEL_W-1:0];
   wire wr_modulus = latch_rise && (word_sel == fastlock_pkg::SEL_MODULUS_EXT);
   wire wr_fastlock = latch_rise && (word_sel == fastlock_pkg::SEL_FASTLOCK);

   // Edge detectors reset to the idle low pin level, so reset makes no false edge
   // Only the last 24 bits before the latch rise count; older bits fall off the top
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         sclk_d_ff <= 1'b0;
         latch_d_ff <= 1'b0;
         shift_ff <= '0;
      end else begin
         sclk_d_ff <= pins_sync.sclk;
         latch_d_ff <= pins_sync.latch;
         if (sclk_rise) begin
            shift_ff <= {shift_ff[22:0], pins_sync.sdata};
         end
      end
   end

   // A word with any other select code is dropped without a trace
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         fn_hi_ff <= fastlock_pkg::RST_HI;
         fd_hi_ff <= fastlock_pkg::RST_HI;
         cfg_ff <= {fastlock_pkg::RST_CSR, fastlock_pkg::RST_CPF, fastlock_pkg::RST_TOC};
      end else begin
         if (wr_modulus) begin
            fd_hi_ff <= shift_ff[fastlock_pkg::FD_HI_LSB +: fastlock_pkg::HI_W];
            fn_hi_ff <= shift_ff[fastlock_pkg::FN_HI_LSB +: fastlock_pkg::HI_W];
         end
         if (wr_fastlock) begin
            cfg_ff.cycle_slip_reduction <= shift_ff[fastlock_pkg::CSR_LSB +: fastlock_pkg::CSR_W];
            cfg_ff.cpf <= shift_ff[fastlock_pkg::CPF_LSB +: fastlock_pkg::CPF_W];
            cfg_ff.toc <= shift_ff[fastlock_pkg::TOC_LSB +: fastlock_pkg::TOC_W];
         end
      end
   end

   // Modulus assembly
   // Narrow mode shows zeros above bit 11, never stale stored bits
   wire [21:0] num_eff = wide_mode_in ? {fn_hi_ff, frac_num_lo_in}
                                      : {10'h000, frac_num_lo_in};
   wire [21:0] den_eff = wide_mode_in ? {fd_hi_ff, frac_den_lo_in}
                                      : {10'h000, frac_den_lo_in};

   // Fastlock sequencing
   wire toc_manual = (cfg_ff.toc == fastlock_pkg::TOC_MANUAL);
   wire toc_timed = (cfg_ff.toc >= fastlock_pkg::TOC_TIMED_MIN);
   wire [CNT_W-1:0] period = {cfg_ff.toc, 1'b0};

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      case (state_ff)
         fastlock_pkg::FL_IDLE: begin
            if (toc_manual) begin
               nxt_state = fastlock_pkg::FL_MANUAL;
            end else if (toc_timed && fastlock_start_in) begin
               nxt_state = fastlock_pkg::FL_TIMED;
               nxt_cnt = period;
            end
         end
         fastlock_pkg::FL_TIMED: begin
            // A rewrite to a non-timed code aborts the period at once
            // A start pulse reloads the period and wins over an event in the same cycle
            if (!toc_timed) begin
               nxt_state = toc_manual ? fastlock_pkg::FL_MANUAL : fastlock_pkg::FL_IDLE;
            end else if (fastlock_start_in) begin
               nxt_cnt = period;
            end else if (comp_event_in) begin
               if (cnt_ff <= CNT_W'(1)) begin
                  nxt_state = fastlock_pkg::FL_IDLE;
                  nxt_cnt = '0;
               end else begin
                  nxt_cnt = cnt_ff - CNT_W'(1);
               end
            end
         end
         fastlock_pkg::FL_MANUAL: begin
            // Manual mode holds until the code moves off 1
            if (!toc_manual) begin
               nxt_state = fastlock_pkg::FL_IDLE;
            end
         end
         default: begin
            nxt_state = fastlock_pkg::FL_IDLE;
            nxt_cnt = '0;
         end
      endcase
   end

   // Active follows the next state so all registered outputs move together
   wire nxt_active = (nxt_state != fastlock_pkg::FL_IDLE);

   // Pin function is decoded from the timeout code alone
   wire toc_hiz = (cfg_ff.toc == fastlock_pkg::TOC_HIZ);
   wire toc_gpo_low = (cfg_ff.toc == fastlock_pkg::TOC_GPO_LOW);
   wire toc_gpo_high = (cfg_ff.toc == fastlock_pkg::TOC_GPO_HIGH);

   // Pin: timed mode pulls low only while active, otherwise released
   // Releasing the timed pin outside fastlock leaves its idle level to an external pull
   logic nxt_pin;
   logic nxt_pin_oe;
   always_comb begin
      nxt_pin = 1'b0;
      nxt_pin_oe = 1'b0;
      if (toc_hiz) begin
         nxt_pin_oe = 1'b0;
      end else if (toc_gpo_high) begin
         nxt_pin = 1'b1;
         nxt_pin_oe = 1'b1;
      end else if (toc_gpo_low) begin
         nxt_pin_oe = 1'b1;
      end else if (toc_manual) begin
         nxt_pin_oe = 1'b1;
      end else if (toc_timed) begin
         nxt_pin_oe = nxt_active;
      end
   end

   // The boost applies only inside fastlock; outside it the pump keeps its base current
   wire [4:0] nxt_pump = nxt_active ? ({1'b0, cfg_ff.cpf} + 5'h01)
                                    : fastlock_pkg::PUMP_MULT_IDLE;
   wire [4:0] nxt_csr = (cfg_ff.cycle_slip_reduction == 2'h0) ? 5'h01 :
                        (cfg_ff.cycle_slip_reduction == 2'h1) ? 5'h02 :
                        (cfg_ff.cycle_slip_reduction == 2'h2) ? 5'h04 : 5'h10;

   // Every output leaves a flop so the pins never see decode glitches
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         state_ff <= fastlock_pkg::FL_IDLE;
         cnt_ff <= '0;
         fastlock_active_out <= 1'b0;
         pump_mult_out <= fastlock_pkg::PUMP_MULT_IDLE;
         csr_divide_out <= 5'h01;
         fastlock_pin_out <= 1'b0;
         fastlock_pin_oe_out <= 1'b0;
         rf_frac_numerator_out <= '0;
         rf_frac_denominator_out <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         fastlock_active_out <= nxt_active;
         pump_mult_out <= nxt_pump;
         csr_divide_out <= nxt_csr;
         fastlock_pin_out <= nxt_pin;
         fastlock_pin_oe_out <= nxt_pin_oe;
         rf_frac_numerator_out <= num_eff;
         rf_frac_denominator_out <= den_eff;
      end
   end
endmodule // rf_fastlock_and_frac_modulus

// ### dv/host_serial_model.sv
// Host model that shifts programming words into the serial pins
`timescale 1ns/1ps
module host_serial_model (
   input wire logic clk_in, // Bench clock
   output fastlock_pkg::serial_pins_s pins_out // Serial clock, data, latch
);
   initial pins_out = '0;
   // Every level is held 3 clocks or more so the 2-flop synchronisers cannot miss it
   task automatic send(input logic [23:0] w);
      for (int i = 23; i >= 0; i--) begin
         @(posedge clk_in) pins_out.sdata <= w[i];
         @(posedge clk_in) pins_out.sclk <= 1'b1;
         repeat (3) @(posedge clk_in);
         pins_out.sclk <= 1'b0;
         repeat (2) @(posedge clk_in);
      end
      pins_out.latch <= 1'b1;
      repeat (3) @(posedge clk_in);
      pins_out.latch <= 1'b0;
      // Data no longer qualified: show the inverse, not the last bit
      pins_out.sdata <= ~pins_out.sdata;
   endtask
endmodule // host_serial_model

// ### dv/rf_fastlock_and_frac_modulus_chk.sv
// Port assertions for the fastlock and fractional modulus block
`timescale 1ns/1ps
module rf_fastlock_and_frac_modulus_chk #(
   parameter int TOC_WIDTH = 14
) (
   input wire logic clk_in, // Clock
   input wire logic resetn_in, // Reset, active low
   input wire fastlock_pkg::serial_pins_s serial_in, // Serial pins
   input wire logic wide_mode_in, // Wide select
   input wire logic [11:0] frac_num_lo_in, // Lower numerator
   input wire logic [11:0] frac_den_lo_in, // Lower denominator
   input wire logic comp_event_in, // Comparison event
   input wire logic [21:0] rf_frac_numerator_out, // Numerator
   input wire logic [21:0] rf_frac_denominator_out, // Denominator
   input wire logic fastlock_active_out, // In fastlock
   input wire logic [4:0] pump_mult_out, // Pump multiplier
   input wire logic [4:0] csr_divide_out, // Rate divisor
   input wire logic fastlock_pin_out, // Pin level
   input wire logic fastlock_pin_oe_out // Pin enable
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   // Cycles since the latch was last high; config may only move shortly after it
   logic [3:0] quiet_ff;
   logic [3:0] nxt_quiet;
   assign nxt_quiet = serial_in.latch ? 4'h0 : quiet_ff + {3'h0, quiet_ff != 4'hf};
   always_ff @(posedge clk_in) quiet_ff <= resetn_in ? nxt_quiet : 4'h0;
   sequence hold_s;
      fastlock_active_out && !comp_event_in && quiet_ff > 4'h8;
   endsequence
   sequence end_s;
      $fell(fastlock_active_out) && quiet_ff > 4'h8;
   endsequence
   num_narrow_a:
      assert property (!wide_mode_in |=> rf_frac_numerator_out == {10'h000, $past(frac_num_lo_in)})
      else $error("narrow numerator wrong");
   num_wide_a:
      assert property (wide_mode_in |=> rf_frac_numerator_out[11:0] == $past(frac_num_lo_in))
      else $error("wide numerator low bits wrong");
   den_narrow_a:
      assert property (!wide_mode_in |=>
         rf_frac_denominator_out == {10'h000, $past(frac_den_lo_in)})
      else $error("narrow denominator wrong");
   den_wide_a:
      assert property (wide_mode_in |=> rf_frac_denominator_out[11:0] == $past(frac_den_lo_in))
      else $error("wide denominator low bits wrong");
   pump_idle_a:
      assert property (!fastlock_active_out |-> pump_mult_out == 5'h01)
      else $error("pump boosted outside fastlock");
   csr_steady_a:
      assert property ($changed(csr_divide_out) |-> quiet_ff < 4'h4)
      else $error("divisor moved without a word");
   pin_active_a:
      assert property (fastlock_active_out |-> fastlock_pin_oe_out && !fastlock_pin_out)
      else $error("pin not driven low in fastlock");
   hold_active_a:
      assert property (hold_s |=> fastlock_active_out)
      else $error("fastlock left without an event");
   end_event_a:
      assert property (end_s |-> $past(comp_event_in))
      else $error("fastlock ended off an event");
endmodule // rf_fastlock_and_frac_modulus_chk
bind rf_fastlock_and_frac_modulus rf_fastlock_and_frac_modulus_chk #(.TOC_WIDTH(TOC_WIDTH))
   rf_fastlock_and_frac_modulus_chk_i (.clk_in(clk_in), .resetn_in(resetn_in),
   .serial_in(serial_in), .wide_mode_in(wide_mode_in), .frac_num_lo_in(frac_num_lo_in),
   .frac_den_lo_in(frac_den_lo_in), .comp_event_in(comp_event_in),
   .rf_frac_numerator_out(rf_frac_numerator_out),
   .rf_frac_denominator_out(rf_frac_denominator_out),
   .fastlock_active_out(fastlock_active_out), .pump_mult_out(pump_mult_out),
   .csr_divide_out(csr_divide_out), .fastlock_pin_out(fastlock_pin_out),
   .fastlock_pin_oe_out(fastlock_pin_oe_out));

// ### dv/tb_rf_fastlock_and_frac_modulus.sv
// Self-checking bench for the fastlock and fractional modulus block
`timescale 1ns/1ps
module tb_rf_fastlock_and_frac_modulus;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic wide = 1'b0, ev = 1'b0, start = 1'b0, act_w, pin_w, oe_w;
   logic [11:0] n_lo = 12'h000, d_lo = 12'h000;
   logic [21:0] num_w, den_w;
   logic [4:0] pump_w, csr_w;
   fastlock_pkg::serial_pins_s ser_w;
   int error_cnt = 0, n_tests = 0, seed = 35, cycles = 0, hi_n = 0, hi_d = 0, toc, cpf;
   always #50 clk_in = ~clk_in;
   host_serial_model host_serial_model_i (.clk_in(clk_in), .pins_out(ser_w));
   rf_fastlock_and_frac_modulus rf_fastlock_and_frac_modulus_i (.clk_in(clk_in),
      .resetn_in(resetn_in), .serial_in(ser_w), .wide_mode_in(wide), .frac_num_lo_in(n_lo),
      .frac_den_lo_in(d_lo), .comp_event_in(ev), .fastlock_start_in(start),
      .rf_frac_numerator_out(num_w), .rf_frac_denominator_out(den_w), .fastlock_active_out(act_w),
      .pump_mult_out(pump_w), .csr_divide_out(csr_w), .fastlock_pin_out(pin_w),
      .fastlock_pin_oe_out(oe_w));
   task automatic chk(input string nm, input logic [21:0] exp, input logic [21:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic stop_test;
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         stop_test();
      end
   end
   task automatic mod_chk(input bit top);
      for (int m = 0; m < 2; m++) begin
         @(posedge clk_in);
         wide <= m[0];
         n_lo <= top ? 12'hfff : 12'($random(seed));
         d_lo <= top ? 12'hfff : 12'($random(seed));
         repeat (2) @(posedge clk_in);
         @(negedge clk_in);
         chk("numerator", m ? {hi_n[9:0], n_lo} : {10'h000, n_lo}, num_w);
         chk("denominator", m ? {hi_d[9:0], d_lo} : {10'h000, d_lo}, den_w);
      end
   endtask
   task automatic fl_out(input bit a, input bit oe, input bit pin, input int pm);
      @(negedge clk_in);
      chk("active", 22'(a), 22'(act_w));
      chk("pin oe", 22'(oe), 22'(oe_w));
      chk("pin", 22'(pin), 22'(pin_w));
      chk("pump", 22'(pm), 22'(pump_w));
   endtask
   initial begin
      repeat (8) @(posedge clk_in);
      resetn_in <= 1'b1;
      fl_out(0, 0, 0, 1);
      chk("csr div", 22'h1, 22'(csr_w));
      for (int k = 0; k < 3; k++) begin
         hi_n = (k == 2) ? 'h3ff : $random(seed) & 'h3ff;
         hi_d = (k == 2) ? 'h3ff : $random(seed) & 'h3ff;
         host_serial_model_i.send({hi_d[9:0], hi_n[9:0], fastlock_pkg::SEL_MODULUS_EXT});
         mod_chk(k == 2);
      end
      // Any other select code must leave the stored bits alone
      host_serial_model_i.send({20'h00000, 4'ha});
      mod_chk(0);
      for (int t = 0; t < 4; t++) begin
         host_serial_model_i.send({2'h0, 4'h5, t[13:0], fastlock_pkg::SEL_FASTLOCK});
         @(posedge clk_in) start <= 1'b1;
         @(posedge clk_in) start <= 1'b0;
         repeat (2) @(posedge clk_in);
         fl_out(t == 1, t != 0, t == 3, t == 1 ? 6 : 1);
      end
      for (int c = 0; c < 4; c++) begin
         toc = 4 + c;
         cpf = $random(seed) & 15;
         host_serial_model_i.send({c[1:0], cpf[3:0], toc[13:0],
            fastlock_pkg::SEL_FASTLOCK});
         repeat (3) @(posedge clk_in);
         fl_out(0, 0, 0, 1);
         chk("csr div", c == 3 ? 22'h10 : 22'h1 << c, 22'(csr_w));
         @(posedge clk_in) start <= 1'b1;
         @(posedge clk_in) start <= 1'b0;
         for (int e = 0; e < 2 * toc; e++) begin
            fl_out(1, 1, 0, cpf + 1);
            @(posedge clk_in) ev <= 1'b1;
            @(posedge clk_in) ev <= 1'b0;
         end
         fl_out(0, 0, 0, 1);
      end
      // A restart reloads the whole period; a code below 4 aborts at once
      host_serial_model_i.send({2'h0, 4'h0, 14'h0004, fastlock_pkg::SEL_FASTLOCK});
      for (int r = 0; r < 10; r++) begin
         if (r == 0 || r == 3) begin
            @(posedge clk_in) start <= 1'b1;
            @(posedge clk_in) start <= 1'b0;
         end
         @(posedge clk_in) ev <= 1'b1;
         @(posedge clk_in) ev <= 1'b0;
      end
      fl_out(1, 1, 0, 1);
      @(posedge clk_in) ev <= 1'b1;
      @(posedge clk_in) ev <= 1'b0;
      fl_out(0, 0, 0, 1);
      @(posedge clk_in) start <= 1'b1;
      @(posedge clk_in) start <= 1'b0;
      fl_out(1, 1, 0, 1);
      host_serial_model_i.send({2'h0, 4'h0, 14'h0002, fastlock_pkg::SEL_FASTLOCK});
      repeat (2) @(posedge clk_in);
      fl_out(0, 1, 0, 1);
      stop_test();
   end
endmodule // tb_rf_fastlock_and_frac_modulus
